// >>> rtl/config_setup_pkg.sv
// constants, types and timing counts for the configuration setup sequencer
// Contract
// - power-up, clear memory, sample mode, then load
// - clear on power-up, program, reprogram, fallback
// - user I/Os high impedance while clearing
// - init low, released after por/latency delay
// - init held low externally stalls initialization
// - unlimited program low; then clear twice
// - sample mode pins on init rising
// - master modes drive config clock pin
// - sample data on config clock rising
// - program low resets and postpones configuration
// - later init lows ignored after rising
// - init becomes open-drain crc error output
package config_setup_pkg;

	// core clock period
	localparam int unsigned CLK_PERIOD_NS = 10;
	// power-on reset delay and program latency, plain defaults
	localparam int unsigned POR_DELAY_NS = 20000;
	localparam int unsigned PROG_LATENCY_NS = 5000;
	// least times round up to whole cycles
	localparam int unsigned POR_DELAY_CYCLES = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PROG_LATENCY_CYCLES = (PROG_LATENCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned DELAY_W = 16;

	// config clock half period in core cycles (12.5 MHz by default)
	localparam int unsigned CONFIG_CLOCK_PIN_HALF_CYCLES = 4;
	localparam int unsigned DIV_W = 8;

	// clearing engine
	localparam int unsigned CLEAR_ADDR_W = 10;
	localparam logic [1:0] CLEAR_PASSES_ONCE = 2'h1;
	localparam logic [1:0] CLEAR_PASSES_TWICE = 2'h2;

	// mode pins and which of the four codes are master modes
	localparam int unsigned MODE_W = 2;
	localparam logic [3:0] MASTER_MODE_MASK = 4'h3;
	localparam logic [1:0] MODE_RESET = 2'h0;

	// configuration data width
	localparam int unsigned DATA_W = 8;

	typedef enum logic [2:0] {
		ST_POR_START,
		ST_PROG_HOLD,
		ST_CLEARING,
		ST_INIT_WAIT,
		ST_LOAD
	} seq_state_t;

endpackage : config_setup_pkg

// >>> rtl/config_setup_sequencer.sv
// setup phase of configuration: clearing, init pin, mode sampling, config clock
`timescale 1ns/1ps
module config_setup_sequencer
	import config_setup_pkg::*;
#(
	parameter int unsigned POR_CYCLES = POR_DELAY_CYCLES,
	parameter int unsigned LATENCY_CYCLES = PROG_LATENCY_CYCLES,
	parameter int unsigned HALF_CYCLES = CONFIG_CLOCK_PIN_HALF_CYCLES,
	parameter int unsigned D_W = DATA_W
)(
	input wire logic SYS_CLK_IN, // 100 MHz core clock
	input wire logic RSTN_IN, // power-on reset, async, active low
	input wire logic PROGRAM_N_IN, // program request pin, active low
	input wire logic JTAG_REPROGRAM_INSTR_IN, // one-cycle pulse
	input wire logic INTERNAL_REPROGRAM_CMD_IN, // one-cycle pulse
	input wire logic FALLBACK_RETRY_IN, // one-cycle pulse
	input wire logic INIT_N_IN, // init status pin level
	input wire logic [MODE_W-1:0] MODE_IN, // mode select pins
	input wire logic CONFIG_CLOCK_PIN_IN, // config clock pin level
	input wire logic [D_W-1:0] CFG_DATA_IN, // config data pins
	input wire logic CRC_ERROR_IN, // crc error level from later logic
	output logic INIT_N_OUT, // init pin output value, always low
	output logic INIT_N_OE_OUT, // high while pulling init low
	output logic USER_IO_HIZ_OUT, // high: user I/Os high impedance
	output logic CONFIG_CLOCK_PIN_OUT, // config clock drive value
	output logic CONFIG_CLOCK_PIN_OE_OUT, // high in master modes
	output logic [MODE_W-1:0] MODE_OUT, // held sampled mode
	output logic MASTER_MODE_OUT, // sampled mode is master
	output logic LOAD_ACTIVE_OUT, // setup done, loading may run
	output logic [D_W-1:0] CFG_DATA_OUT, // captured data word
	output logic CFG_DATA_VALID_OUT, // one-cycle pulse per capture
	output logic [CLEAR_ADDR_W-1:0] CLEAR_ADDR_OUT, // memory clear address
	output logic CLEAR_WE_OUT // memory clear write strobe
);

	typedef struct packed {
		seq_state_t st;
		logic [DELAY_W-1:0] delay;
		logic clear_done;
		logic clear_start;
		logic [1:0] passes;
		logic [2:0] prog_s;
		logic [2:0] init_s;
		logic [2:0] config_clock_pin_s;
		logic [2:0][MODE_W-1:0] mode_s;
		logic [2:0][D_W-1:0] data_s;
		logic prog_q;
		logic init_q;
		logic config_clock_pin_q;
		logic config_clock_pin_prev;
		logic [MODE_W-1:0] mode_q;
		logic [D_W-1:0] data_q;
		logic [MODE_W-1:0] mode;
		logic master;
		logic [DIV_W-1:0] div;
		logic config_clock_pin_out;
		logic [D_W-1:0] data_out;
		logic data_valid;
		logic init_drive;
		logic hiz;
	} seq_t;

	localparam logic [DELAY_W-1:0] POR_LOAD = DELAY_W'(POR_CYCLES);
	localparam logic [DELAY_W-1:0] LATENCY_LOAD = DELAY_W'(LATENCY_CYCLES);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_CYCLES - 1);

	seq_t cur;
	seq_t next_cur;
	logic clear_done_pulse;
	logic clear_abort;
	logic reprogram_req;
	logic config_clock_pin_tick;
	logic config_clock_pin_rise;

	// master modes are those whose bit is set in the mask
	function automatic logic is_master(input logic [MODE_W-1:0] mode);
		is_master = MASTER_MODE_MASK[mode];
	endfunction : is_master

	// a change counts once the 2nd and 3rd stage agree
	function automatic logic agreed_bit(input logic [2:0] s, input logic q);
		agreed_bit = (s[1] == s[2]) ? s[2] : q;
	endfunction : agreed_bit

	// held program pin keeps the walker stopped
	assign clear_abort = (cur.st == ST_PROG_HOLD);
	assign reprogram_req = JTAG_REPROGRAM_INSTR_IN | INTERNAL_REPROGRAM_CMD_IN | FALLBACK_RETRY_IN;
	assign config_clock_pin_tick = (cur.div == DIV_LAST);
	// rising edge of our own clock or of the incoming one
	assign config_clock_pin_rise = cur.master ? (config_clock_pin_tick & ~cur.config_clock_pin_out) : (cur.config_clock_pin_q & ~cur.config_clock_pin_prev);

	// sequence of setup steps and pin handling
	always_comb
	begin
		next_cur = cur;
		next_cur.clear_start = 1'b0;
		next_cur.data_valid = 1'b0;

		// three-stage pin synchronisers
		next_cur.prog_s = {cur.prog_s[1:0], PROGRAM_N_IN};
		next_cur.init_s = {cur.init_s[1:0], INIT_N_IN};
		next_cur.config_clock_pin_s = {cur.config_clock_pin_s[1:0], CONFIG_CLOCK_PIN_IN};
		next_cur.mode_s = {cur.mode_s[1:0], MODE_IN};
		next_cur.data_s = {cur.data_s[1:0], CFG_DATA_IN};
		next_cur.prog_q = agreed_bit(cur.prog_s, cur.prog_q);
		next_cur.init_q = agreed_bit(cur.init_s, cur.init_q);
		next_cur.config_clock_pin_q = agreed_bit(cur.config_clock_pin_s, cur.config_clock_pin_q);
		next_cur.config_clock_pin_prev = cur.config_clock_pin_q;
		if (cur.mode_s[1] == cur.mode_s[2])
			next_cur.mode_q = cur.mode_s[2];
		if (cur.data_s[1] == cur.data_s[2])
			next_cur.data_q = cur.data_s[2];

		// a finished sweep is remembered until the delay also ends
		if (clear_done_pulse)
			next_cur.clear_done = 1'b1;

		case (cur.st)
			ST_POR_START:
			begin
				// power-up is the first step, then clearing
				next_cur.passes = CLEAR_PASSES_ONCE;
				next_cur.clear_start = 1'b1;
				next_cur.clear_done = 1'b0;
				// power-up case waits the por delay
				next_cur.delay = POR_LOAD;
				next_cur.init_drive = 1'b1;
				next_cur.hiz = 1'b1;
				next_cur.st = ST_CLEARING;
			end
			ST_PROG_HOLD:
			begin
				// no limit on how long program stays low
				if (cur.prog_q)
				begin
					next_cur.passes = CLEAR_PASSES_TWICE;
					next_cur.clear_start = 1'b1;
					next_cur.clear_done = 1'b0;
					next_cur.delay = LATENCY_LOAD;
					next_cur.st = ST_CLEARING;
				end
			end
			ST_CLEARING:
			begin
				if (cur.delay != '0)
					next_cur.delay = cur.delay - 1'b1;
				// release init once delay and sweep are over
				if ((cur.delay == '0) && cur.clear_done)
				begin
					next_cur.init_drive = 1'b0;
					// user I/Os leave high impedance after clearing
					next_cur.hiz = 1'b0;
					next_cur.st = ST_INIT_WAIT;
				end
			end
			ST_INIT_WAIT:
			begin
				// stall while someone else holds init low
				if (cur.init_q)
				begin
					next_cur.mode = cur.mode_q;
					// master modes take over the clock pin
					next_cur.master = is_master(cur.mode_q);
					next_cur.div = '0;
					next_cur.config_clock_pin_out = 1'b0;
					next_cur.st = ST_LOAD;
				end
			end
			ST_LOAD:
			begin
				// init pin lows no longer delay anything
				// init pulled low only on a crc error
				next_cur.init_drive = CRC_ERROR_IN;
				// divider enable paces the master clock
				if (cur.master)
				begin
					next_cur.div = config_clock_pin_tick ? '0 : cur.div + 1'b1;
					if (config_clock_pin_tick)
						next_cur.config_clock_pin_out = ~cur.config_clock_pin_out;
				end
				// capture data on each rising clock edge
				if (config_clock_pin_rise)
				begin
					next_cur.data_out = cur.data_q;
					next_cur.data_valid = 1'b1;
				end
			end
			default:
			begin
				next_cur.st = ST_POR_START;
			end
		endcase

		// reprogram instruction, command or fallback retry
		if (reprogram_req && (cur.st != ST_POR_START))
		begin
			next_cur.passes = CLEAR_PASSES_ONCE;
			next_cur.clear_start = 1'b1;
			next_cur.clear_done = 1'b0;
			next_cur.delay = LATENCY_LOAD;
			next_cur.init_drive = 1'b1;
			next_cur.hiz = 1'b1;
			next_cur.master = 1'b0;
			next_cur.config_clock_pin_out = 1'b0;
			// a capture pulse must not outlive the load phase
			next_cur.data_valid = 1'b0;
			next_cur.st = ST_CLEARING;
		end

		// program low overrides every step and postpones it
		if (!cur.prog_q)
		begin
			next_cur.clear_start = 1'b0;
			next_cur.init_drive = 1'b1;
			next_cur.hiz = 1'b1;
			next_cur.master = 1'b0;
			next_cur.config_clock_pin_out = 1'b0;
			next_cur.data_valid = 1'b0;
			next_cur.st = ST_PROG_HOLD;
		end
	end

	// program pin sync stages reset high so an idle pin is not seen as a request
	always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
	begin
		if (!RSTN_IN)
		begin
			cur <= '0;
			cur.st <= ST_POR_START;
			cur.prog_s <= 3'h7;
			cur.prog_q <= 1'b1;
			cur.init_drive <= 1'b1;
			cur.hiz <= 1'b1;
			cur.mode <= MODE_RESET;
		end
		else
		begin
			cur <= next_cur;
		end
	end

	memory_clear_engine #(
		.ADDR_W(CLEAR_ADDR_W)
	) u_clear (
		.clk_in(SYS_CLK_IN),
		.rstn_in(RSTN_IN),
		.start_in(cur.clear_start),
		.abort_in(clear_abort),
		.passes_in(cur.passes),
		.addr_out(CLEAR_ADDR_OUT),
		.we_out(CLEAR_WE_OUT),
		.done_out(clear_done_pulse)
	);

	// open-drain init: only the enable moves
	assign INIT_N_OUT = 1'b0;
	assign INIT_N_OE_OUT = cur.init_drive;
	// high impedance while memory is being cleared
	assign USER_IO_HIZ_OUT = cur.hiz;
	assign CONFIG_CLOCK_PIN_OUT = cur.config_clock_pin_out;
	assign CONFIG_CLOCK_PIN_OE_OUT = cur.master;
	assign MODE_OUT = cur.mode;
	assign MASTER_MODE_OUT = cur.master;
	assign LOAD_ACTIVE_OUT = (cur.st == ST_LOAD);
	assign CFG_DATA_OUT = cur.data_out;
	assign CFG_DATA_VALID_OUT = cur.data_valid;

endmodule : config_setup_sequencer

// >>> rtl/memory_clear_engine.sv
// sequential configuration memory clear walker, one or more passes
`timescale 1ns/1ps
module memory_clear_engine
	import config_setup_pkg::*;
#(
	parameter int unsigned ADDR_W = CLEAR_ADDR_W
)(
	input wire logic clk_in, // core clock
	input wire logic rstn_in, // async reset, active low
	input wire logic start_in, // one-cycle start pulse
	input wire logic abort_in, // level, stops walking
	input wire logic [1:0] passes_in, // number of full sweeps
	output logic [ADDR_W-1:0] addr_out, // frame address being cleared
	output logic we_out, // clear write strobe
	output logic done_out // one-cycle pulse after last write
);

	typedef struct packed {
		logic busy;
		logic [1:0] passes;
		logic [ADDR_W-1:0] addr;
		logic done;
	} clr_t;

	clr_t cur;
	clr_t next_cur;

	// walk every address, restart the sweep until passes run out
	always_comb
	begin
		next_cur = cur;
		next_cur.done = 1'b0;
		if (abort_in)
		begin
			next_cur.busy = 1'b0;
		end
		else if (start_in)
		begin
			next_cur.busy = 1'b1;
			next_cur.passes = passes_in;
			next_cur.addr = '0;
		end
		else if (cur.busy)
		begin
			next_cur.addr = cur.addr + 1'b1;
			if (&cur.addr)
			begin
				next_cur.passes = cur.passes - 2'h1;
				if (cur.passes <= 2'h1)
				begin
					next_cur.busy = 1'b0;
					next_cur.done = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in)
	begin
		if (!rstn_in)
			cur <= '0;
		else
			cur <= next_cur;
	end

	assign addr_out = cur.addr;
	assign we_out = cur.busy;
	assign done_out = cur.done;

endmodule : memory_clear_engine

// >>> testbench/board_ctrl.sv
// board model: init pull-up with optional hold, program pin driver
`timescale 1ns/1ps
module board_ctrl #(
	parameter int unsigned PROG_MIN = 4
)(
	input wire logic clk_in, // core clock
	input wire logic init_val_in, // device init value
	input wire logic init_oe_in, // device init drive
	input wire logic hold_init_in, // hold init low
	input wire logic prog_req_in, // program request
	output logic init_wire_out, // resolved init wire
	output logic program_n_out // program pin
);
	logic [7:0] stretch = 8'h00;
	// short requests stretched to the least width
	always_ff @(posedge clk_in)
		stretch <= prog_req_in ? 8'(PROG_MIN) : stretch - 8'(stretch != 8'h00);
	assign program_n_out = !(prog_req_in || stretch != 8'h00);
	// pull-up wins unless someone pulls low
	assign init_wire_out = !((init_oe_in && !init_val_in) || hold_init_in);
endmodule : board_ctrl

// >>> testbench/config_setup_chk.sv
// port assertions for the setup sequencer
`timescale 1ns/1ps
module config_setup_chk
	import config_setup_pkg::*;
(
	input wire logic SYS_CLK_IN, // clock
	input wire logic RSTN_IN, // reset
	input wire logic PROGRAM_N_IN, // program pin
	input wire logic CRC_ERROR_IN, // crc level
	input wire logic INIT_N_OUT, // init value
	input wire logic INIT_N_OE_OUT, // init drive
	input wire logic USER_IO_HIZ_OUT, // io high-z
	input wire logic CONFIG_CLOCK_PIN_OE_OUT, // clock drive
	input wire logic [MODE_W-1:0] MODE_OUT, // held mode
	input wire logic MASTER_MODE_OUT, // master flag
	input wire logic LOAD_ACTIVE_OUT, // load phase
	input wire logic CFG_DATA_VALID_OUT, // capture pulse
	input wire logic CLEAR_WE_OUT // clear strobe
);
	default clocking @(posedge SYS_CLK_IN); endclocking
	default disable iff (!RSTN_IN);
	a_clear_hiz: assert property (CLEAR_WE_OUT |-> USER_IO_HIZ_OUT && INIT_N_OE_OUT)
		else $error("io or init released while clearing");
	a_load_order: assert property ($rose(LOAD_ACTIVE_OUT) |-> !$past(INIT_N_OE_OUT) && !CLEAR_WE_OUT)
		else $error("load before init release");
	a_mode_held: assert property (LOAD_ACTIVE_OUT && $past(LOAD_ACTIVE_OUT) |-> $stable(MODE_OUT))
		else $error("mode changed in load");
	a_master_decode: assert property (LOAD_ACTIVE_OUT |-> MASTER_MODE_OUT == MASTER_MODE_MASK[MODE_OUT])
		else $error("master flag wrong");
	a_slave_no_clk: assert property (!MASTER_MODE_OUT |-> !CONFIG_CLOCK_PIN_OE_OUT)
		else $error("clock driven in slave mode");
	a_prog_hold: assert property (!PROGRAM_N_IN [*7] |-> INIT_N_OE_OUT && !LOAD_ACTIVE_OUT && !CLEAR_WE_OUT)
		else $error("program low not holding");
	a_crc_init: assert property (LOAD_ACTIVE_OUT && $past(LOAD_ACTIVE_OUT) |-> INIT_N_OE_OUT == $past(CRC_ERROR_IN))
		else $error("init not following crc");
	a_valid_pulse: assert property (CFG_DATA_VALID_OUT |-> LOAD_ACTIVE_OUT ##1 !CFG_DATA_VALID_OUT)
		else $error("capture outside load");
	a_init_od: assert property (INIT_N_OUT == 1'b0)
		else $error("init value not low");
	c_master: cover property ($rose(LOAD_ACTIVE_OUT) && MASTER_MODE_OUT);
	c_capture: cover property (CFG_DATA_VALID_OUT);
	c_prog: cover property (!PROGRAM_N_IN [*6]);
endmodule : config_setup_chk

// >>> testbench/tb.sv
// self-checking bench for the setup sequencer
`timescale 1ns/1ps
module tb;
	import config_setup_pkg::*;
	typedef struct {logic [1:0] mode; int trig; logic master;} row_t;
	row_t rows[4] = '{'{2'h0, 0, 1'b1}, '{2'h1, 1, 1'b1}, '{2'h2, 2, 1'b0}, '{2'h3, 3, 1'b0}};
	logic clk = 0, rstn = 0, jtag = 0, icmd = 0, fb = 0, crc = 0, hold = 0, preq = 0, sclk = 0;
	logic [1:0] mode = 2'h0;
	logic [7:0] data = 8'h00;
	logic init_v, oe, wire_i, prog_n, hiz, ccoe, master, load, valid, we_o, config_clock_pin_o, c0;
	logic [9:0] addr_o;
	logic [1:0] mode_o;
	logic [7:0] data_o;
	int mismatches = 0, n_checks = 0, cyc = 0, we, n;
	always #5 clk = !clk;
	board_ctrl u_board (.clk_in(clk), .init_val_in(init_v), .init_oe_in(oe), .hold_init_in(hold),
		.prog_req_in(preq), .init_wire_out(wire_i), .program_n_out(prog_n));
	config_setup_sequencer #(.POR_CYCLES(1500), .LATENCY_CYCLES(8), .HALF_CYCLES(2)) i_config_setup_sequencer (
		.SYS_CLK_IN(clk), .RSTN_IN(rstn), .PROGRAM_N_IN(prog_n), .JTAG_REPROGRAM_INSTR_IN(jtag),
		.INTERNAL_REPROGRAM_CMD_IN(icmd), .FALLBACK_RETRY_IN(fb), .INIT_N_IN(wire_i), .MODE_IN(mode),
		.CONFIG_CLOCK_PIN_IN(sclk), .CFG_DATA_IN(data), .CRC_ERROR_IN(crc), .INIT_N_OUT(init_v),
		.INIT_N_OE_OUT(oe), .USER_IO_HIZ_OUT(hiz), .CONFIG_CLOCK_PIN_OUT(config_clock_pin_o), .CONFIG_CLOCK_PIN_OE_OUT(ccoe),
		.MODE_OUT(mode_o), .MASTER_MODE_OUT(master), .LOAD_ACTIVE_OUT(load), .CFG_DATA_OUT(data_o),
		.CFG_DATA_VALID_OUT(valid), .CLEAR_ADDR_OUT(addr_o), .CLEAR_WE_OUT(we_o));
	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH %s exp %h seen %h", what, exp, seen);
		end
	endtask : check
	// counts clear writes and cycles until the device lets go of init
	task automatic settle(output int w, output int c);
		int a;
		w = 0;
		c = 0;
		a = 0;
		@(negedge clk);
		while (oe !== 1'b0 && c < 4000)
		begin
			a += int'(we_o === 1'b1 && addr_o !== 10'(w));
			w += int'(we_o === 1'b1);
			c++;
			@(negedge clk);
		end
		check("clear addr", 16'(a), 16'h0);
	endtask : settle
	task automatic load_wait;
		int k;
		k = 0;
		while (load !== 1'b1 && k < 20)
		begin
			k++;
			@(negedge clk);
		end
		check("load active", load, 1);
	endtask : load_wait
	// one-cycle reprogram pulse, or a long program pin hold for k 3
	task automatic fire(input int k);
		jtag = k == 0;
		icmd = k == 1;
		fb = k == 2;
		preq = k == 3;
		repeat (k == 3 ? 300 : 1) @(negedge clk);
		check("hold init", oe, 1);
		check("hold load", load, 0);
		{jtag, icmd, fb, preq} = 4'h0;
	endtask : fire
	// hang guard, well above the expected run length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			mismatches++;
			conclude();
		end
	end
	initial
	begin
		repeat (2) @(negedge clk);
		rstn = 1;
		settle(we, n);
		check("por writes", 16'(we), 1024);
		check("por delay", n >= 1495, 1);
		load_wait();
		foreach (rows[i])
		begin
			mode = rows[i].mode;
			fire(rows[i].trig);
			settle(we, n);
			check("clear writes", 16'(we), rows[i].trig == 3 ? 2048 : 1024);
			check("hiz off", hiz, 0);
			load_wait();
			check("mode", mode_o, rows[i].mode);
			check("master", master, rows[i].master);
			check("clock drive", ccoe, rows[i].master);
			c0 = config_clock_pin_o;
			repeat (2) @(negedge clk);
			check("clock toggle", config_clock_pin_o, rows[i].master ? !c0 : 1'b0);
		end
		// slave capture on the pin clock
		data = 8'h5a;
		sclk = 1;
		for (n = 0; n < 10 && valid !== 1'b1; n++)
			@(negedge clk);
		check("valid", valid, 1'b1);
		check("data", data_o, 8'h5a);
		sclk = 0;
		mode = 2'h0;
		hold = 1;
		repeat (10) @(negedge clk);
		check("mode kept", mode_o, 3);
		check("init low ignored", load, 1);
		hold = 0;
		crc = 1;
		repeat (3) @(negedge clk);
		check("crc init", oe, 1);
		crc = 0;
		repeat (3) @(negedge clk);
		check("crc clear", oe, 0);
		// board holds init low across the release
		hold = 1;
		mode = 2'h1;
		fire(1);
		settle(we, n);
		repeat (50) @(negedge clk);
		check("stalled", load, 0);
		hold = 0;
		load_wait();
		check("mode after stall", mode_o, 1);
		rstn = 0;
		@(negedge clk);
		check("rst init", oe, 1);
		check("rst hiz", hiz, 1);
		check("rst mode", mode_o, 0);
		conclude();
	end
endmodule : tb
bind config_setup_sequencer config_setup_chk i_config_setup_chk (.SYS_CLK_IN, .RSTN_IN, .PROGRAM_N_IN,
	.CRC_ERROR_IN, .INIT_N_OUT, .INIT_N_OE_OUT, .USER_IO_HIZ_OUT, .CONFIG_CLOCK_PIN_OE_OUT, .MODE_OUT,
	.MASTER_MODE_OUT, .LOAD_ACTIVE_OUT, .CFG_DATA_VALID_OUT, .CLEAR_WE_OUT);
